// ### hw/acsf_pkg.sv
// Constants, encodings and conversion helpers for the analog channel scaling filter.
// Assumes one system clock, a synchronous reset and AHB-Lite register access.
package acsf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Structure
  localparam int NUM_CH = 2;
  localparam int CH_W = 1;
  localparam int WIN = 4;
  localparam int CNT_W = 3;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 17;
  localparam int LVL_W = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Signal forms and filter modes
  localparam logic [2:0] FORM_MA4_20 = 3'h0;
  localparam logic [2:0] FORM_MA0_20 = 3'h1;
  localparam logic [2:0] FORM_V1_5 = 3'h2;
  localparam logic [2:0] FORM_V0_10 = 3'h3;
  localparam logic [2:0] FORM_TC_J = 3'h4;
  localparam logic [2:0] FORM_TC_K = 3'h5;
  localparam logic [2:0] FORM_TC_E = 3'h6;
  localparam logic [2:0] FORM_TC_S = 3'h7;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_MEAN = 2'h1;
  localparam logic [1:0] FILT_MEDIAN = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_AO_VALUE = 8'h08;
  localparam logic [7:0] OFS_AO_CONV = 8'h0C;
  localparam logic [7:0] OFS_REGION = 8'h10;
  localparam logic [7:0] OFS_UNMAPPED = 8'hFF;
  localparam int CTRL_FORM_LSB = 0;
  localparam int CTRL_FORM_STEP = 4;
  localparam int CTRL_FILT_LSB = 8;
  localparam int CTRL_AO_LSB = 12;
  localparam int STAT_LVL_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_3033;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3F77;
  localparam logic [15:0] AO_RST = 16'h0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion spans (reported units at full code) and detection limits
  localparam logic [31:0] SPAN_MA = 32'h0000_61A8;
  localparam logic [31:0] SPAN_V5 = 32'h0000_1770;
  localparam logic [31:0] SPAN_V10 = 32'h0000_2EE0;
  localparam logic [31:0] SPAN_TC = 32'h0000_4A38;
  localparam logic [15:0] TC_BASE = 16'hF574;
  localparam logic [15:0] LIM_ZERO = 16'h0000;
  localparam logic [15:0] LIM_MA4_LO = 16'h0F50;
  localparam logic [15:0] LIM_MA_HI = 16'h4FB0;
  localparam logic [15:0] LIM_V5_LO = 16'h03C0;
  localparam logic [15:0] LIM_V5_HI = 16'h13EC;
  localparam logic [15:0] LIM_V10_HI = 16'h27D8;
  localparam logic [15:0] LIM_J_LO = 16'hF7CC;
  localparam logic [15:0] LIM_J_HI = 16'h2EE0;
  localparam logic [15:0] LIM_KE_LO = 16'hF574;
  localparam logic [15:0] LIM_K_HI = 16'h32C8;
  localparam logic [15:0] LIM_E_HI = 16'h2710;
  localparam logic [15:0] LIM_S_LO = 16'hFE0C;
  localparam logic [15:0] LIM_S_HI = 16'h3E80;

  typedef enum logic [1:0] {FS_IDLE = 2'b01, FS_CALC = 2'b10} acsf_fstate_t;

  function automatic logic signed [15:0] formLo(input logic [2:0] f);
    logic [15:0] r;
    r = LIM_ZERO;
    unique case (f)
      FORM_MA4_20: r = LIM_MA4_LO;
      FORM_MA0_20: r = LIM_ZERO;
      FORM_V1_5: r = LIM_V5_LO;
      FORM_V0_10: r = LIM_ZERO;
      FORM_TC_J: r = LIM_J_LO;
      FORM_TC_K: r = LIM_KE_LO;
      FORM_TC_E: r = LIM_KE_LO;
      FORM_TC_S: r = LIM_S_LO;
    endcase
    return $signed(r);
  endfunction : formLo

  function automatic logic signed [15:0] formHi(input logic [2:0] f);
    logic [15:0] r;
    r = LIM_ZERO;
    unique case (f)
      FORM_MA4_20: r = LIM_MA_HI;
      FORM_MA0_20: r = LIM_MA_HI;
      FORM_V1_5: r = LIM_V5_HI;
      FORM_V0_10: r = LIM_V10_HI;
      FORM_TC_J: r = LIM_J_HI;
      FORM_TC_K: r = LIM_K_HI;
      FORM_TC_E: r = LIM_E_HI;
      FORM_TC_S: r = LIM_S_HI;
    endcase
    return $signed(r);
  endfunction : formHi

  // Span wider than the detection range so that over-range codes stay visible
  function automatic logic signed [15:0] convert(input logic [2:0] f, input logic [15:0] raw);
    logic [31:0] span;
    logic [31:0] prod;
    logic [15:0] base;
    span = SPAN_TC;
    if (f == FORM_MA4_20 || f == FORM_MA0_20) span = SPAN_MA;
    else if (f == FORM_V1_5) span = SPAN_V5;
    else if (f == FORM_V0_10) span = SPAN_V10;
    prod = 32'(raw) * span;
    base = f[2] ? TC_BASE : LIM_ZERO;
    return $signed(prod[31:16] + base);
  endfunction : convert

endpackage : acsf_pkg

// ### hw/acsf_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module acsf_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [LW-1:0] count_q, count_d;
  logic push, pop;

  assign inReady = count_q != LW'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem_q[rdPtr_q];
  assign level = count_q;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = AW'(wrPtr_q + 1'b1);
    end
    if (pop) rdPtr_d = AW'(rdPtr_q + 1'b1);
    if (push && !pop) count_d = LW'(count_q + 1'b1);
    else if (pop && !push) count_d = LW'(count_q - 1'b1);
  end

  always_ff @(posedge clock) begin
    mem_q <= mem_d;
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end
endmodule : acsf_fifo
`default_nettype wire

// ### hw/acsf_filter.sv
// Per-channel sliding-window filter: none, arithmetic mean, median average.
// Assumes samples arrive already scaled; takes two cycles per sample.
`timescale 1ns/10ps
`default_nettype none
module acsf_filter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [acsf_pkg::CH_W-1:0] inCh,
  input wire logic signed [15:0] inValue,
  input wire logic [2*acsf_pkg::NUM_CH-1:0] filtModes,
  input wire logic [acsf_pkg::NUM_CH-1:0] flush,
  output logic resValid,
  output logic [acsf_pkg::CH_W-1:0] resCh,
  output logic signed [15:0] resValue
);
  acsf_pkg::acsf_fstate_t state_q, state_d;
  logic signed [15:0] win_q [acsf_pkg::NUM_CH][acsf_pkg::WIN];
  logic signed [15:0] win_d [acsf_pkg::NUM_CH][acsf_pkg::WIN];
  logic [acsf_pkg::CNT_W-1:0] cnt_q [acsf_pkg::NUM_CH];
  logic [acsf_pkg::CNT_W-1:0] cnt_d [acsf_pkg::NUM_CH];
  logic [acsf_pkg::CH_W-1:0] cur_q, cur_d, resCh_q, resCh_d;
  logic resValid_q, resValid_d;
  logic signed [15:0] resValue_q, resValue_d, maxC, minC;
  logic signed [19:0] sumC;
  logic [1:0] mode;
  logic full;

  assign inReady = state_q == acsf_pkg::FS_IDLE;
  assign resValid = resValid_q;
  assign resCh = resCh_q;
  assign resValue = resValue_q;
  assign mode = filtModes[2*int'(cur_q) +: 2];
  assign full = cnt_q[cur_q] == acsf_pkg::CNT_W'(acsf_pkg::WIN);

  ////////////////////////////////////////////////////////////////////////////////
  // Window statistics
  always_comb begin
    sumC = '0;
    maxC = win_q[cur_q][0];
    minC = win_q[cur_q][0];
    for (int i = 0; i < acsf_pkg::WIN; i++) begin
      sumC = sumC + 20'(win_q[cur_q][i]);
      if (win_q[cur_q][i] > maxC) maxC = win_q[cur_q][i];
      if (win_q[cur_q][i] < minC) minC = win_q[cur_q][i];
    end
  end

  always_comb begin
    state_d = state_q;
    win_d = win_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    resValid_d = 1'b0;
    resCh_d = resCh_q;
    resValue_d = resValue_q;
    unique case (state_q)
      acsf_pkg::FS_IDLE: begin
        if (inValid) begin
          for (int i = acsf_pkg::WIN - 1; i > 0; i--) win_d[inCh][i] = win_q[inCh][i-1];
          win_d[inCh][0] = inValue;
          if (cnt_q[inCh] < acsf_pkg::CNT_W'(acsf_pkg::WIN)) begin
            cnt_d[inCh] = acsf_pkg::CNT_W'(cnt_q[inCh] + 1'b1);
          end
          cur_d = inCh;
          state_d = acsf_pkg::FS_CALC;
        end
      end
      acsf_pkg::FS_CALC: begin
        resValid_d = 1'b1;
        resCh_d = cur_q;
        state_d = acsf_pkg::FS_IDLE;
        // Partly filled window passes the newest sample
        if (mode == acsf_pkg::FILT_NONE || !full) begin
          resValue_d = win_q[cur_q][0];
        end else if (mode == acsf_pkg::FILT_MEDIAN) begin
          resValue_d = 16'((sumC - 20'(maxC) - 20'(minC)) / (acsf_pkg::WIN - 2));
        end else begin
          resValue_d = 16'(sumC / acsf_pkg::WIN);
        end
      end
    endcase
    for (int i = 0; i < acsf_pkg::NUM_CH; i++) begin
      if (flush[i]) cnt_d[i] = '0;
    end
  end

  always_ff @(posedge clock) begin
    win_q <= win_d;
    if (sys_rst) begin
      state_q <= acsf_pkg::FS_IDLE;
      for (int i = 0; i < acsf_pkg::NUM_CH; i++) cnt_q[i] <= '0;
      cur_q <= '0;
      resValid_q <= 1'b0;
      resCh_q <= '0;
      resValue_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
      resValid_q <= resValid_d;
      resCh_q <= resCh_d;
      resValue_q <= resValue_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cbF @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_none_pass;
    state_q == acsf_pkg::FS_CALC && mode == acsf_pkg::FILT_NONE
      |=> resValid && resValue == $past(win_q[cur_q][0]);
  endproperty
  a_none_pass: assert property (p_none_pass) else $error("unfiltered value differs");

  property p_mean;
    state_q == acsf_pkg::FS_CALC && mode == acsf_pkg::FILT_MEAN && full
      |=> resValue >= $past(minC) && resValue <= $past(maxC) && resCh == $past(cur_q);
  endproperty
  a_mean: assert property (p_mean) else $error("mean outside window");

  property p_median;
    state_q == acsf_pkg::FS_CALC && mode == acsf_pkg::FILT_MEDIAN && full && $past(inValid)
      |=> resValid ##1 !resValid;
  endproperty
  a_median: assert property (p_median) else $error("median result not one pulse");

  property p_median_const;
    state_q == acsf_pkg::FS_CALC && mode == acsf_pkg::FILT_MEDIAN && full && maxC == minC
      |=> resValue == $past(minC);
  endproperty
  a_median_const: assert property (p_median_const) else $error("median of flat window");

  property p_refill;
    flush[0] && !(state_q == acsf_pkg::FS_IDLE && inValid && inCh == '0) |=> cnt_q[0] == '0;
  endproperty
  a_refill: assert property (p_refill) else $error("window not refilled");

  c_median: cover property (state_q == acsf_pkg::FS_CALC && mode == acsf_pkg::FILT_MEDIAN && full);
endmodule : acsf_filter
`default_nettype wire

// ### hw/acsf_top.sv
// Analog channel scaling filter: scaling, range check, FIFO, filter, input region, output clamp.
// Assumes a single AHB-Lite master, word transfers only, and samples synchronous to clock.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Current forms report milliamperes times 1000
// - Voltage forms report volts times 1000
// - Thermocouple forms report degrees times 10
// - Out-of-range input warns and sends fault report
// - Output value clamped to its signal range
// - Each channel one two-byte slot, even start
// - Channels packed upward in fixed-span region
// - Raw sample scaled linearly per chosen form
// - Filter none passes converted sample unchanged
// - Mean mode averages sliding window
// - Median mode drops max and min, averages
module acsf_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [acsf_pkg::CH_W-1:0] sampleCh,
  input wire logic [15:0] sampleRaw,
  output logic faultValid,
  output logic [acsf_pkg::CH_W-1:0] faultCh,
  output logic [acsf_pkg::NUM_CH-1:0] rangeWarn,
  output logic [1:0] dacForm,
  output logic [15:0] dacValue
);
  logic addrTake;
  logic dpValid_q, dpValid_d, dpWrite_q, dpWrite_d, rdWait_q, rdWait_d;
  logic [7:0] dpAddr_q, dpAddr_d;
  logic [31:0] hrdata_q, hrdata_d, ctrl_q, ctrl_d;
  logic wrHit, wrCtrl, wrStat, wrAo;
  logic [acsf_pkg::NUM_CH-1:0] warn_q, warn_d, flush;
  logic signed [15:0] aoVal_q, aoVal_d, dac_q, dac_d, aoLo, aoHi;
  logic signed [15:0] slot_q [acsf_pkg::NUM_CH];
  logic signed [15:0] slot_d [acsf_pkg::NUM_CH];
  logic faultValid_q, faultValid_d;
  logic [acsf_pkg::CH_W-1:0] faultCh_q, faultCh_d;
  logic [2:0] inForm;
  logic signed [15:0] conv;
  logic outRange, sampleAcc;
  logic fifoInReady, fifoOutValid, filtReady;
  logic [acsf_pkg::FIFO_W-1:0] fifoInData, fifoOutData;
  logic [acsf_pkg::LVL_W-1:0] fifoLevel;
  logic resValid;
  logic [acsf_pkg::CH_W-1:0] resCh;
  logic signed [15:0] resValue;

  function automatic logic [2:0] formOf(input logic [31:0] c, input logic [acsf_pkg::CH_W-1:0] ch);
    return c[acsf_pkg::CTRL_FORM_LSB + acsf_pkg::CTRL_FORM_STEP*int'(ch) +: 3];
  endfunction : formOf

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign addrTake = hsel && hready && htrans[1];
  assign hreadyout = !rdWait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wrHit = dpValid_q && dpWrite_q;
  assign wrCtrl = wrHit && dpAddr_q == acsf_pkg::OFS_CTRL;
  assign wrStat = wrHit && dpAddr_q == acsf_pkg::OFS_STATUS;
  assign wrAo = wrHit && dpAddr_q == acsf_pkg::OFS_AO_VALUE;

  always_comb begin
    dpValid_d = addrTake && hsize == acsf_pkg::HSIZE_WORD;
    dpWrite_d = hwrite;
    dpAddr_d = (haddr[31:8] == 24'h000000) ? haddr[7:0] : acsf_pkg::OFS_UNMAPPED;
    rdWait_d = addrTake && !hwrite;
    hrdata_d = hrdata_q;
    if (rdWait_q) begin
      // Read mux sampled one cycle late so a write just before is seen
      case (dpAddr_q)
        acsf_pkg::OFS_CTRL: hrdata_d = ctrl_q;
        acsf_pkg::OFS_STATUS: begin
          hrdata_d = (32'(fifoLevel) << acsf_pkg::STAT_LVL_LSB) | 32'(warn_q);
        end
        acsf_pkg::OFS_AO_VALUE: hrdata_d = {16'h0000, aoVal_q};
        acsf_pkg::OFS_AO_CONV: hrdata_d = {16'h0000, dac_q};
        acsf_pkg::OFS_REGION: hrdata_d = {slot_q[1], slot_q[0]};
        default: hrdata_d = 32'h0000_0000;
      endcase
      if (!dpValid_q) hrdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dpValid_q <= 1'b0;
      dpWrite_q <= 1'b0;
      dpAddr_q <= 8'h00;
      rdWait_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      dpValid_q <= dpValid_d;
      dpWrite_q <= dpWrite_d;
      dpAddr_q <= dpAddr_d;
      rdWait_q <= rdWait_d;
      hrdata_q <= hrdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scaling and detection range
  assign inForm = formOf(ctrl_q, sampleCh);
  assign conv = acsf_pkg::convert(inForm, sampleRaw);
  assign outRange = conv < acsf_pkg::formLo(inForm) || conv > acsf_pkg::formHi(inForm);
  assign sampleAcc = sampleValid && fifoInReady;
  assign sampleReady = fifoInReady;
  assign fifoInData = {sampleCh, conv};

  ////////////////////////////////////////////////////////////////////////////////
  // Control, status, output clamp and input region
  assign dacForm = ctrl_q[acsf_pkg::CTRL_AO_LSB +: 2];
  assign aoLo = acsf_pkg::formLo({1'b0, dacForm});
  assign aoHi = acsf_pkg::formHi({1'b0, dacForm});
  assign dacValue = dac_q;
  assign rangeWarn = warn_q;
  assign faultValid = faultValid_q;
  assign faultCh = faultCh_q;

  always_comb begin
    ctrl_d = ctrl_q;
    aoVal_d = aoVal_q;
    warn_d = warn_q;
    flush = '0;
    if (wrCtrl) begin
      ctrl_d = hwdata & acsf_pkg::CTRL_MASK;
      for (int i = 0; i < acsf_pkg::NUM_CH; i++) begin
        flush[i] = formOf(ctrl_d, acsf_pkg::CH_W'(i)) != formOf(ctrl_q, acsf_pkg::CH_W'(i));
      end
    end
    if (wrAo) aoVal_d = $signed(hwdata[15:0]);
    if (wrStat) warn_d = warn_q & ~hwdata[acsf_pkg::NUM_CH-1:0];
    // Set wins over a clear in the same cycle
    if (sampleAcc && outRange) warn_d[sampleCh] = 1'b1;
    faultValid_d = sampleAcc && outRange;
    faultCh_d = sampleAcc ? sampleCh : faultCh_q;
    // Clamp stays ahead of the converter; dacValue keeps the old form's clamp for one cycle after a dacForm change
    if (aoVal_q > aoHi) dac_d = aoHi;
    else if (aoVal_q < aoLo) dac_d = aoLo;
    else dac_d = aoVal_q;
    slot_d = slot_q;
    if (resValid) slot_d[resCh] = resValue;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= acsf_pkg::CTRL_RST;
      aoVal_q <= acsf_pkg::AO_RST;
      warn_q <= '0;
      dac_q <= acsf_pkg::AO_RST;
      faultValid_q <= 1'b0;
      faultCh_q <= '0;
      for (int i = 0; i < acsf_pkg::NUM_CH; i++) slot_q[i] <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      aoVal_q <= aoVal_d;
      warn_q <= warn_d;
      dac_q <= dac_d;
      faultValid_q <= faultValid_d;
      faultCh_q <= faultCh_d;
      slot_q <= slot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample buffer and filter
  acsf_fifo #(
    .WIDTH(acsf_pkg::FIFO_W),
    .DEPTH(acsf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(sampleValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(filtReady),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  acsf_filter u_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(fifoOutValid),
    .inReady(filtReady),
    .inCh(fifoOutData[acsf_pkg::FIFO_W-1 -: acsf_pkg::CH_W]),
    .inValue($signed(fifoOutData[15:0])),
    .filtModes(ctrl_q[acsf_pkg::CTRL_FILT_LSB +: 2*acsf_pkg::NUM_CH]),
    .flush(flush),
    .resValid(resValid),
    .resCh(resCh),
    .resValue(resValue)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cbT @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_current;
    sampleAcc && (inForm == acsf_pkg::FORM_MA4_20 || inForm == acsf_pkg::FORM_MA0_20)
      |-> fifoInData[15:0] == 16'((32'(sampleRaw) * 32'd25000) >> 16);
  endproperty
  a_current: assert property (p_current) else $error("current scaling wrong");

  property p_voltage;
    sampleAcc && inForm == acsf_pkg::FORM_V0_10
      |-> fifoInData[15:0] == 16'((32'(sampleRaw) * 32'd12000) >> 16);
  endproperty
  a_voltage: assert property (p_voltage) else $error("voltage scaling wrong");

  property p_thermo;
    sampleAcc && inForm[2] |-> conv >= -16'sd2700 && conv <= 16'sd16300;
  endproperty
  a_thermo: assert property (p_thermo) else $error("temperature out of span");

  property p_fault;
    sampleAcc && outRange |=> faultValid && faultCh == $past(sampleCh) && rangeWarn[faultCh];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");

  property p_clamp_hi;
    aoVal_q > aoHi |=> dac_q == $past(aoHi);
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("output not held at upper limit");

  property p_clamp_lo;
    aoVal_q < aoLo |=> dac_q == $past(aoLo);
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("output not held at lower limit");

  property p_clamp_pass;
    aoVal_q >= aoLo && aoVal_q <= aoHi |=> dac_q == $past(aoVal_q);
  endproperty
  a_clamp_pass: assert property (p_clamp_pass) else $error("in-range output altered");

  property p_region;
    rdWait_q && dpValid_q && dpAddr_q == acsf_pkg::OFS_REGION
      |=> hreadyout && hrdata == {$past(slot_q[1]), $past(slot_q[0])};
  endproperty
  a_region: assert property (p_region) else $error("region word wrong");

  property p_slot;
    resValid |=> slot_q[$past(resCh)] == $past(resValue);
  endproperty
  a_slot: assert property (p_slot) else $error("slot not updated");

  property p_zero_point;
    sampleAcc && sampleRaw == 16'h0000 |-> conv == (inForm[2] ? -16'sd2700 : 16'sd0);
  endproperty
  a_zero_point: assert property (p_zero_point) else $error("conversion offset wrong");

  c_fault: cover property (faultValid);
  c_full: cover property (sampleValid && !sampleReady);
  c_clamp: cover property (aoVal_q < aoLo ##1 dac_q == aoLo);
endmodule : acsf_top
`default_nettype wire

// ### dv/acsf_host_model.sv
// Host CPU model: single AHB-Lite master for the block registers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/10ps
`default_nettype none
module acsf_host_model (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Waits on hready with no assumed latency
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clock);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
    // Stale data inverted so it is never mistaken for a live value
    hwdata <= ~d;
  endtask : xfer
endmodule : acsf_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench: scaling, range faults, filters, output clamp.
// Assumes hsel tied high and hready looped from hreadyout.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, sysRst, sampleValid, sampleCh, faultValid, faultCh, hready, hresp;
  logic hwrite, sampleReady, lastFaultCh;
  logic [1:0] htrans, rangeWarn, dacForm;
  logic [2:0] hsize;
  logic [15:0] sampleRaw, dacValue;
  logic [31:0] haddr, hwdata, hrdata;
  int miscompares = 0, nChecks = 0, faults = 0;
  acsf_host_model host (.clock(clock), .hready(hready), .hrdata(hrdata), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  acsf_top DUT (.clock(clock), .sys_rst(sysRst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleCh(sampleCh), .sampleRaw(sampleRaw),
    .faultValid(faultValid), .faultCh(faultCh), .rangeWarn(rangeWarn),
    .dacForm(dacForm), .dacValue(dacValue));
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Channel of the latest fault pulse, so faultCh is compared as well
  always @(posedge clock) if (faultValid === 1'b1) begin
    faults++;
    lastFaultCh = faultCh;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask : rd
  // Slot settles within 4 edges; 8 leaves margin
  task automatic smp(input logic ch, input logic [15:0] raw);
    sampleValid <= 1'b1;
    sampleCh <= ch;
    sampleRaw <= raw;
    do @(posedge clock); while (sampleReady !== 1'b1);
    sampleValid <= 1'b0;
    sampleRaw <= ~raw;
    repeat (8) @(posedge clock);
  endtask : smp
  task automatic quad();
    smp(1'b0, 16'h1000);
    smp(1'b0, 16'h2000);
    smp(1'b0, 16'h3000);
    smp(1'b0, 16'h8000);
  endtask : quad
  task automatic finish_test();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1ms;
    miscompares++;
    finish_test();
  end
  ////////////////////////////////////////
  initial begin
    sysRst = 1'b1;
    sampleValid = 1'b0;
    sampleCh = 1'b0;
    sampleRaw = 16'h0000;
    repeat (8) @(posedge clock);
    sysRst <= 1'b0;
    @(posedge clock);
    rd(32'h0000_0000, 32'h0000_3033);
    rd(32'h0000_0010, 32'h0000_0000);
    chk({dacForm, dacValue}, {2'h3, 16'h0000});
    chk({31'h0, sampleReady}, 32'h0000_0001);
    $display("test reset done");
    smp(1'b0, 16'h8000);
    smp(1'b1, 16'hFFFF);
    rd(32'h0000_0010, 32'h2EDF_1770);
    chk({30'h0, rangeWarn}, 32'h0000_0002);
    chk(faults, 1);
    chk({31'h0, lastFaultCh}, 32'h0000_0001);
    wr(32'h0000_0004, 32'h0000_0003);
    // Clear lands at the edge that ends the write; look one edge later
    @(posedge clock);
    chk({30'h0, rangeWarn}, 32'h0000_0000);
    $display("test scale done");
    wr(32'h0000_0000, 32'h0000_3102);
    smp(1'b1, 16'h8000);
    quad();
    rd(32'h0000_0010, 32'h30D4_0520);
    chk({31'h0, lastFaultCh}, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_3243);
    smp(1'b1, 16'h0000);
    // Fresh window after the form change passes the newest sample
    smp(1'b0, 16'h1000);
    rd(32'h0000_0010, 32'hF574_02EE);
    quad();
    rd(32'h0000_0010, 32'hF574_0753);
    chk({30'h0, rangeWarn}, 32'h0000_0003);
    chk(faults, 4);
    rd(32'h0000_0004, 32'h0000_0003);
    $display("test filter done");
    rd(32'h0000_0000, 32'h0000_3243);
    wr(32'h0000_0008, 32'h0000_2EE0);
    rd(32'h0000_000C, 32'h0000_27D8);
    wr(32'h0000_0000, 32'h0000_0243);
    wr(32'h0000_0008, 32'h0000_0064);
    // Request lands at one edge, the clamped value one edge after
    repeat (2) @(posedge clock);
    chk({dacForm, dacValue}, {2'h0, 16'h0F50});
    rd(32'h0000_0040, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    $display("test output done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
